// file: inc/uabr_pkg.sv
package uabr_pkg;

    // clock and baud figures
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned BAUD_DEFAULT = 115200;
    localparam int unsigned BAUD_MIN     = 9600;
    localparam int unsigned BAUD_MAX     = 921600;

    // divisor: clock cycles per serial bit
    localparam int unsigned DIV_W = 14;
    localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [DIV_W-1:0] DIV_MIN   = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX   = DIV_W'(CLK_HZ / BAUD_MIN);

    // character framing
    localparam int unsigned DATA_W    = 8;
    localparam logic [2:0]  LAST_BIT  = 3'h7;

    // register bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BUS_W  = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TXD  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RXD  = 8'h10;

    // handshake mode field of the control register
    localparam int unsigned CTRL_HS_LSB = 0;
    localparam logic [1:0]  CTRL_RESET  = 2'h0;
    localparam logic [1:0]  HS_DISABLED = 2'h0;
    localparam logic [1:0]  HS_RTS      = 2'h1;
    localparam logic [1:0]  HS_CTS      = 2'h2;
    localparam logic [1:0]  HS_RTSCTS   = 2'h3;

    // status register bit positions
    localparam int unsigned STAT_TX_BUSY   = 0;
    localparam int unsigned STAT_TX_FULL   = 1;
    localparam int unsigned STAT_RX_EMPTY  = 2;
    localparam int unsigned STAT_RX_FULL   = 3;
    localparam int unsigned STAT_FRAME_ERR = 4;
    localparam int unsigned STAT_OVERRUN   = 5;
    localparam int unsigned STAT_CTS_STOP  = 6;
    localparam int unsigned STAT_PORT_EN   = 7;
    localparam int unsigned STAT_RX_CNT    = 8;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uabr_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uabr_rx_e;

endpackage

// file: rtl/uabr_mem.sv
`timescale 1ns/1ps
module uabr_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read port, data registered
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rd_nxt;

    if ((DEPTH < 1) || (DEPTH > (1 << AW)))
    begin : g_chk
        $error("DEPTH must fit the address width");
    end

    // write-first so a fresh byte is visible at once
    always_comb
    begin
        rd_nxt = mem_r[rd_addr];
        if (wr_en && (wr_addr == rd_addr))
        begin
            rd_nxt = wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= rd_nxt;
        end
    end

endmodule // uabr_mem

// file: rtl/uabr_bridge.sv
`timescale 1ns/1ps
module uabr_bridge
    import uabr_pkg::*;
#(
    parameter int unsigned RX_DEPTH = 16
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    // register port
    input  wire logic [uabr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [uabr_pkg::BUS_W-1:0]  reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [uabr_pkg::BUS_W-1:0]  reg_rdata,
    // serial link to the target
    input  wire logic                     port_enable,
    input  wire logic                     target_txd,
    output logic                          target_rxd,
    input  wire logic                     target_rts_n,
    output logic                          target_cts_n,
    output logic                          target_cts_oe_n
);
    import uabr_pkg::*;

    localparam int unsigned PTR_W = $clog2(RX_DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);
    localparam logic [CNT_W-1:0] CNT_STOP = CNT_W'(RX_DEPTH - 1);

    if ((RX_DEPTH < 2) || (RX_DEPTH != (1 << PTR_W)))
    begin : g_chk
        $error("RX_DEPTH must be a power of two, at least 2");
    end

    // register state
    logic [1:0]        mode_r, mode_nxt;
    logic [DIV_W-1:0]  div_r, div_nxt;
    logic              frame_err_r, frame_err_nxt;
    logic              overrun_r, overrun_nxt;
    logic [BUS_W-1:0]  rdata_r, rdata_nxt;
    // transmit state
    uabr_tx_e          tx_state_r, tx_state_nxt;
    logic [DIV_W-1:0]  tx_cnt_r, tx_cnt_nxt;
    logic [2:0]        tx_bit_r, tx_bit_nxt;
    logic [DATA_W-1:0] tx_shift_r, tx_shift_nxt;
    logic [DATA_W-1:0] hold_r, hold_nxt;
    logic              hold_full_r, hold_full_nxt;
    logic              line_r, line_nxt;
    // receive state
    uabr_rx_e          rx_state_r, rx_state_nxt;
    logic [DIV_W-1:0]  rx_cnt_r, rx_cnt_nxt;
    logic [2:0]        rx_bit_r, rx_bit_nxt;
    logic [DATA_W-1:0] rx_shift_r, rx_shift_nxt;
    logic              rx_prev_r, rx_prev_nxt;
    logic              rx_push;
    logic              rx_bad;
    // receive buffer state
    logic [PTR_W-1:0]  wr_ptr_r, wr_ptr_nxt;
    logic [PTR_W-1:0]  rd_ptr_r, rd_ptr_nxt;
    logic [CNT_W-1:0]  count_r, count_nxt;
    logic [DATA_W-1:0] head;
    // pin drivers
    logic              cts_n_r, cts_n_nxt;
    logic              cts_oe_n_r, cts_oe_n_nxt;

    logic              rx_empty;
    logic              rx_full;
    logic              push_ok;
    logic              pop;
    logic              rts_ok;
    logic              cts_stop;
    logic              wr_txd;
    logic [DIV_W-1:0]  div_last;
    logic [DIV_W-1:0]  div_half;

    assign rx_empty = (count_r == '0);
    assign rx_full  = (count_r == CNT_FULL);
    assign push_ok  = rx_push && !rx_full;
    assign pop      = reg_rd && (reg_addr == OFS_RXD) && !rx_empty;
    assign wr_txd   = reg_wr && (reg_addr == OFS_TXD);
    assign div_last = div_r - DIV_W'(1);
    assign div_half = (div_r >> 1) - DIV_W'(1);
    // stop early: one slot left for the target's last character
    assign cts_stop = (count_r >= CNT_STOP);
    // request-to-send gates only in transmit-gating modes
    assign rts_ok   = !((mode_r == HS_CTS) || (mode_r == HS_RTSCTS))
                      || !target_rts_n;

    // register file
    always_comb
    begin
        mode_nxt      = mode_r;
        div_nxt       = div_r;
        frame_err_nxt = frame_err_r;
        overrun_nxt   = overrun_r;
        rdata_nxt     = '0;
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_CTRL: mode_nxt = reg_wdata[CTRL_HS_LSB +: 2];
                OFS_BAUD:
                begin
                    // accept only divisors within the baud range
                    if ((reg_wdata >= BUS_W'(DIV_MIN))
                        && (reg_wdata <= BUS_W'(DIV_MAX)))
                    begin
                        div_nxt = reg_wdata[DIV_W-1:0];
                    end
                end
                OFS_STAT:
                begin
                    if (reg_wdata[STAT_FRAME_ERR])
                    begin
                        frame_err_nxt = 1'b0;
                    end
                    if (reg_wdata[STAT_OVERRUN])
                    begin
                        overrun_nxt = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (rx_bad)
        begin
            frame_err_nxt = 1'b1;
        end
        if (rx_push && rx_full)
        begin
            overrun_nxt = 1'b1;
        end
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_CTRL: rdata_nxt[CTRL_HS_LSB +: 2] = mode_r;
                OFS_BAUD: rdata_nxt[DIV_W-1:0] = div_r;
                OFS_STAT:
                begin
                    rdata_nxt[STAT_TX_BUSY]   = (tx_state_r != TX_IDLE);
                    rdata_nxt[STAT_TX_FULL]   = hold_full_r;
                    rdata_nxt[STAT_RX_EMPTY]  = rx_empty;
                    rdata_nxt[STAT_RX_FULL]   = rx_full;
                    rdata_nxt[STAT_FRAME_ERR] = frame_err_r;
                    rdata_nxt[STAT_OVERRUN]   = overrun_r;
                    rdata_nxt[STAT_CTS_STOP]  = cts_stop;
                    rdata_nxt[STAT_PORT_EN]   = port_enable;
                    rdata_nxt[STAT_RX_CNT +: CNT_W] = count_r;
                end
                OFS_RXD:
                begin
                    if (!rx_empty)
                    begin
                        rdata_nxt[DATA_W-1:0] = head;
                    end
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    // reset values: 115200 divisor, handshake disabled
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_r      <= CTRL_RESET;
            div_r       <= DIV_RESET;
            frame_err_r <= 1'b0;
            overrun_r   <= 1'b0;
            rdata_r     <= '0;
        end
        else
        begin
            mode_r      <= mode_nxt;
            div_r       <= div_nxt;
            frame_err_r <= frame_err_nxt;
            overrun_r   <= overrun_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // transmitter toward the target
    always_comb
    begin
        tx_state_nxt  = tx_state_r;
        tx_cnt_nxt    = tx_cnt_r + DIV_W'(1);
        tx_bit_nxt    = tx_bit_r;
        tx_shift_nxt  = tx_shift_r;
        hold_nxt      = hold_r;
        hold_full_nxt = hold_full_r;
        line_nxt      = line_r;
        // a write to a full holding register is dropped
        if (wr_txd && !hold_full_r)
        begin
            hold_nxt      = reg_wdata[DATA_W-1:0];
            hold_full_nxt = 1'b1;
        end
        case (tx_state_r)
            TX_IDLE:
            begin
                tx_cnt_nxt = '0;
                line_nxt   = 1'b1;
                // start only with the port enabled
                if (hold_full_r && port_enable && rts_ok)
                begin
                    tx_shift_nxt  = hold_r;
                    hold_full_nxt = 1'b0;
                    tx_state_nxt  = TX_START;
                    line_nxt      = 1'b0;
                end
            end
            TX_START:
            begin
                if (tx_cnt_r >= div_last)
                begin
                    tx_cnt_nxt   = '0;
                    tx_bit_nxt   = '0;
                    tx_state_nxt = TX_DATA;
                    line_nxt     = tx_shift_r[0];
                end
            end
            TX_DATA:
            begin
                // no request-to-send check until the character ends
                if (tx_cnt_r >= div_last)
                begin
                    tx_cnt_nxt   = '0;
                    tx_shift_nxt = tx_shift_r >> 1;
                    if (tx_bit_r == LAST_BIT)
                    begin
                        tx_state_nxt = TX_STOP;
                        line_nxt     = 1'b1;
                    end
                    else
                    begin
                        tx_bit_nxt = tx_bit_r + 3'h1;
                        line_nxt   = tx_shift_r[1];
                    end
                end
            end
            TX_STOP:
            begin
                if (tx_cnt_r >= div_last)
                begin
                    tx_cnt_nxt   = '0;
                    tx_state_nxt = TX_IDLE;
                end
            end
            default:
            begin
                tx_state_nxt = TX_IDLE;
                line_nxt     = 1'b1;
            end
        endcase
        // dropping the enable aborts and idles the line
        if (!port_enable)
        begin
            tx_state_nxt = TX_IDLE;
            tx_cnt_nxt   = '0;
            line_nxt     = 1'b1;
        end
    end

    // bridge drives the target receive line
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_r  <= TX_IDLE;
            tx_cnt_r    <= '0;
            tx_bit_r    <= '0;
            tx_shift_r  <= '0;
            hold_r      <= '0;
            hold_full_r <= 1'b0;
            line_r      <= 1'b1;
        end
        else
        begin
            tx_state_r  <= tx_state_nxt;
            tx_cnt_r    <= tx_cnt_nxt;
            tx_bit_r    <= tx_bit_nxt;
            tx_shift_r  <= tx_shift_nxt;
            hold_r      <= hold_nxt;
            hold_full_r <= hold_full_nxt;
            line_r      <= line_nxt;
        end
    end

    // receiver from the target transmit line
    always_comb
    begin
        rx_state_nxt = rx_state_r;
        rx_cnt_nxt   = rx_cnt_r + DIV_W'(1);
        rx_bit_nxt   = rx_bit_r;
        rx_shift_nxt = rx_shift_r;
        rx_prev_nxt  = target_txd;
        rx_push      = 1'b0;
        rx_bad       = 1'b0;
        case (rx_state_r)
            RX_IDLE:
            begin
                rx_cnt_nxt = '0;
                // falling edge marks a start bit
                if (port_enable && rx_prev_r && !target_txd)
                begin
                    rx_state_nxt = RX_START;
                end
            end
            RX_START:
            begin
                if (rx_cnt_r >= div_half)
                begin
                    rx_cnt_nxt   = '0;
                    rx_bit_nxt   = '0;
                    rx_state_nxt = target_txd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (rx_cnt_r >= div_last)
                begin
                    rx_cnt_nxt   = '0;
                    rx_shift_nxt = {target_txd, rx_shift_r[DATA_W-1:1]};
                    if (rx_bit_r == LAST_BIT)
                    begin
                        rx_state_nxt = RX_STOP;
                    end
                    else
                    begin
                        rx_bit_nxt = rx_bit_r + 3'h1;
                    end
                end
            end
            RX_STOP:
            begin
                if (rx_cnt_r >= div_last)
                begin
                    rx_cnt_nxt   = '0;
                    rx_state_nxt = RX_IDLE;
                    rx_push      = target_txd;
                    rx_bad       = !target_txd;
                end
            end
            default: rx_state_nxt = RX_IDLE;
        endcase
        // receiver ignores the line while disabled
        if (!port_enable)
        begin
            rx_state_nxt = RX_IDLE;
            rx_push      = 1'b0;
            rx_bad       = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r   <= '0;
            rx_bit_r   <= '0;
            rx_shift_r <= '0;
            rx_prev_r  <= 1'b1;
        end
        else
        begin
            rx_state_r <= rx_state_nxt;
            rx_cnt_r   <= rx_cnt_nxt;
            rx_bit_r   <= rx_bit_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_prev_r  <= rx_prev_nxt;
        end
    end

    // receive buffer pointers and handshake pin
    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r + PTR_W'(push_ok);
        rd_ptr_nxt = rd_ptr_r + PTR_W'(pop);
        count_nxt  = count_r + CNT_W'(push_ok) - CNT_W'(pop);
        cts_n_nxt    = 1'b1;
        cts_oe_n_nxt = 1'b1;
        case (mode_r)
            HS_RTS, HS_RTSCTS:
            begin
                cts_oe_n_nxt = 1'b0;
                cts_n_nxt    = cts_stop;
            end
            default:
            begin
                cts_oe_n_nxt = 1'b1;
                cts_n_nxt    = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            count_r    <= '0;
            cts_n_r    <= 1'b1;
            cts_oe_n_r <= 1'b1;
        end
        else
        begin
            wr_ptr_r   <= wr_ptr_nxt;
            rd_ptr_r   <= rd_ptr_nxt;
            count_r    <= count_nxt;
            cts_n_r    <= cts_n_nxt;
            cts_oe_n_r <= cts_oe_n_nxt;
        end
    end

    // head byte always follows the next read pointer
    uabr_mem #(
        .WIDTH (DATA_W),
        .DEPTH (RX_DEPTH),
        .AW    (PTR_W)
    ) u_rx_mem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (push_ok),
        .wr_addr (wr_ptr_r),
        .wr_data (rx_shift_r),
        .rd_addr (rd_ptr_nxt),
        .rd_data (head)
    );

    assign reg_rdata       = rdata_r;
    assign target_rxd      = line_r;
    assign target_cts_n    = cts_n_r;
    assign target_cts_oe_n = cts_oe_n_r;

endmodule // uabr_bridge

// file: tb/uabr_bridge_properties.sv
`timescale 1ns/1ps
module uabr_props
    import uabr_pkg::*;
#(
    parameter int unsigned RX_DEPTH = 16
) (
    // clock and reset
    input wire logic                          clk_sys,
    input wire logic                          reset_n,
    // register port
    input wire logic [uabr_pkg::ADDR_W-1:0]   reg_addr,
    input wire logic [uabr_pkg::BUS_W-1:0]    reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [uabr_pkg::BUS_W-1:0]    reg_rdata,
    // serial link
    input wire logic                          port_enable,
    input wire logic                          target_txd,
    input wire logic                          target_rxd,
    input wire logic                          target_rts_n,
    input wire logic                          target_cts_n,
    input wire logic                          target_cts_oe_n
);
    import uabr_pkg::*;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // shadow of the handshake mode field
    always_comb
        mode_nxt = (reg_wr && reg_addr == OFS_CTRL) ? reg_wdata[1:0] : mode_r;
    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            mode_r <= CTRL_RESET;
        else
            mode_r <= mode_nxt;

    chk_mode_read: assert property (
        reg_rd && reg_addr == OFS_CTRL |=> reg_rdata == {30'h0, mode_r})
        else $error("control read back differs");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr == 8'h20 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    chk_stat_enable: assert property (
        reg_rd && reg_addr == OFS_STAT
        |=> reg_rdata[STAT_PORT_EN] == $past(port_enable))
        else $error("status enable bit wrong");
    chk_line_idle: assert property (
        !port_enable ##1 !port_enable |-> target_rxd)
        else $error("line not idle while disabled");
    chk_tx_enabled: assert property (
        $fell(target_rxd) |-> $past(port_enable))
        else $error("line moved while disabled");
    chk_start_width: assert property (
        $fell(target_rxd) |-> (!target_rxd || !port_enable) [*8])
        else $error("start bit too short");
    chk_cts_off: assert property (
        !mode_r[0] && !$past(mode_r[0]) |-> target_cts_oe_n && target_cts_n)
        else $error("clear-to-send driven in undriven mode");
    chk_cts_on: assert property (
        mode_r[0] && $past(mode_r[0]) |-> !target_cts_oe_n)
        else $error("clear-to-send not driven");
endmodule // uabr_props

bind uabr_bridge uabr_props #(.RX_DEPTH(RX_DEPTH)) u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_enable(port_enable),
    .target_txd(target_txd), .target_rxd(target_rxd),
    .target_rts_n(target_rts_n), .target_cts_n(target_cts_n),
    .target_cts_oe_n(target_cts_oe_n));

// file: tb/uabr_target.sv
`timescale 1ns/1ps
module uabr_target #(
    parameter int DIV = 108
) (
    // clock
    input  wire logic clk_sys,
    // serial lines
    input  wire logic rxd,
    output logic      txd,
    input  wire logic cts_n
);
    logic       hs_en = 1'b0;
    logic [7:0] rb;
    logic [7:0] rx_q [$];

    initial txd = 1'b1;

    task send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (hs_en && cts_n)
            @(posedge clk_sys);
        // start low, lsb first, stop high
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_sys);
            txd <= f[i];
            repeat (DIV - 1) @(posedge clk_sys);
        end
    endtask

    // every frame taken, a bad stop shows as inverted data
    always
    begin
        @(negedge rxd);
        repeat (DIV / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            repeat (DIV) @(posedge clk_sys);
            rb[i] = rxd;
        end
        repeat (DIV) @(posedge clk_sys);
        rx_q.push_back(rxd ? rb : ~rb);
    end
endmodule // uabr_target

// file: tb/uabr_bridge_test.sv
`timescale 1ns/1ps
module uabr_bridge_test;
    import uabr_pkg::*;
    localparam int D = 108;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [BUS_W-1:0]  reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [BUS_W-1:0]  reg_rdata;
    logic              port_enable = 1'b0;
    logic              target_rts_n = 1'b1;
    logic              target_txd;
    logic              target_rxd;
    logic              target_cts_n;
    logic              target_cts_oe_n;
    logic              cts_w;
    logic [BUS_W-1:0]  d;
    logic [BUS_W-1:0]  bv [4] = '{32'h6B, 32'h28B1, 32'h28B0, 32'h6C};
    logic [BUS_W-1:0]  be [4] = '{32'h364, 32'h364, 32'h28B0, 32'h6C};
    int                err_count = 0;
    int                n_tests = 0;

    always #5 clk_sys = ~clk_sys;
    // pull-up on the clear-to-send wire
    assign cts_w = target_cts_oe_n ? 1'b1 : target_cts_n;

    uabr_bridge #(.RX_DEPTH(16)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port_enable(port_enable),
        .target_txd(target_txd), .target_rxd(target_rxd),
        .target_rts_n(target_rts_n), .target_cts_n(target_cts_n),
        .target_cts_oe_n(target_cts_oe_n));
    uabr_target #(.DIV(D)) tgt (.clk_sys(clk_sys), .rxd(target_rxd),
        .txd(target_txd), .cts_n(cts_w));

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic bits(input int n);
        repeat (n * D) @(posedge clk_sys);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        stop_test;
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rdchk(OFS_CTRL, 32'h0);
        rdchk(OFS_BAUD, 32'h364);
        rdchk(OFS_STAT, 32'h4);
        rdchk(8'h20, 32'h0);
        chk(32'(target_cts_oe_n), 32'h1);
        chk(32'(target_rxd), 32'h1);
        done("reset");
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_BAUD, bv[i]);
            rdchk(OFS_BAUD, be[i]);
        end
        done("baud");
        // rts left high to show it is ignored when disabled
        @(posedge clk_sys) port_enable <= 1'b1;
        wr(OFS_TXD, 32'h1E);
        bits(12);
        chk(32'(tgt.rx_q.pop_front()), 32'h1E);
        tgt.send_byte(8'h5B);
        tgt.send_byte(8'hC3);
        rdchk(OFS_RXD, 32'h5B);
        rdchk(OFS_RXD, 32'hC3);
        done("data");
        for (int m = 2; m < 4; m++)
        begin
            wr(OFS_CTRL, 32'(m));
            wr(OFS_TXD, 32'h66);
            bits(20);
            chk(32'(tgt.rx_q.size()), 32'h0);
            chk(32'(target_cts_oe_n), 32'(m == 2));
            @(posedge clk_sys) target_rts_n <= 1'b0;
            for (int k = 0; k < 20 && target_rxd; k++)
                @(posedge clk_sys);
            @(posedge clk_sys) target_rts_n <= 1'b1;
            bits(11);
            chk(32'(tgt.rx_q.pop_front()), 32'h66);
        end
        done("gate");
        wr(OFS_CTRL, 32'h1);
        wr(OFS_TXD, 32'h77);
        tgt.hs_en = 1'b1;
        fork
            for (int i = 0; i < 16; i++)
                tgt.send_byte(8'h40 + 8'(i));
        join_none
        bits(200);
        chk(32'(tgt.rx_q.pop_front()), 32'h77);
        rd(OFS_STAT);
        chk((d >> 8) & 32'h1F, 32'hF);
        chk(32'(cts_w), 32'h1);
        rdchk(OFS_RXD, 32'h40);
        bits(15);
        rd(OFS_STAT);
        chk((d >> 8) & 32'h1F, 32'hF);
        for (int i = 1; i < 16; i++)
            rdchk(OFS_RXD, 32'h40 + 32'(i));
        tgt.hs_en = 1'b0;
        done("throttle");
        // seventeen bytes with no throttle: the last one overruns
        for (int i = 0; i < 17; i++)
            tgt.send_byte(8'h50 + 8'(i));
        rdchk(OFS_STAT, 32'h10E8);
        wr(OFS_STAT, 32'h30);
        rdchk(OFS_STAT, 32'h10C8);
        for (int i = 0; i < 16; i++)
            rdchk(OFS_RXD, 32'h50 + 32'(i));
        rdchk(OFS_RXD, 32'h0);
        done("overrun");
        @(posedge clk_sys) port_enable <= 1'b0;
        tgt.send_byte(8'h99);
        rdchk(OFS_STAT, 32'h4);
        wr(OFS_TXD, 32'h12);
        bits(12);
        chk(32'(tgt.rx_q.size()), 32'h0);
        @(posedge clk_sys) port_enable <= 1'b1;
        bits(12);
        chk(32'(tgt.rx_q.pop_front()), 32'h12);
        done("enable");
        stop_test;
    end
endmodule // uabr_bridge_test
